// *** rtl/dirg_defines.svh ***
// Constants of the dual input hold reset generator: times, counts and widths.
// Assumes a 40 MHz system clock; every interval is derived from it.
`ifndef DIRG_DEFINES_SVH
`define DIRG_DEFINES_SVH

`define DIRG_CLK_KHZ         40000
`define DIRG_CLK_MHZ         40

`define DIRG_HOLD_MS_0       500
`define DIRG_HOLD_MS_1       1000
`define DIRG_HOLD_MS_2       1500
`define DIRG_HOLD_MS_3       2000
`define DIRG_HOLD_MS_4       2500
`define DIRG_HOLD_MS_5       3000
`define DIRG_HOLD_MS_6       4000
`define DIRG_HOLD_MS_7       5000

`define DIRG_PULSE_SHORT_US  2200
`define DIRG_PULSE_LONG_US   70000
`define DIRG_TEST_WINDOW_US  35
`define DIRG_TEST_DELAY_US   250
`define DIRG_TEST_PULSES     8

`define DIRG_MS_CYCLES(ms)   ((ms) * `DIRG_CLK_KHZ)
`define DIRG_US_CYCLES(us)   ((us) * `DIRG_CLK_MHZ)

`define DIRG_TIMER_W         28
`define DIRG_WIN_W           11
`define DIRG_EDGE_W          4
`define DIRG_SETTLE_W        2
`define DIRG_SETTLE_LAST     2'h3

`endif

// *** rtl/dirg_pkg.sv ***
// Types of the dual input hold reset generator.
// Assumes dirg_defines.svh is on the include path.
`default_nettype none
`include "dirg_defines.svh"

package dirg_pkg;

    typedef enum logic [1:0] {
        st_idle,
        st_hold,
        st_pulse,
        st_test_wait
    } dirg_state_type;

    // Build option to hold cycles
    function automatic int unsigned dirg_hold_lookup(input logic [2:0] option);
        int unsigned ms;
        case (option)
            3'h0: ms = `DIRG_HOLD_MS_0;
            3'h1: ms = `DIRG_HOLD_MS_1;
            3'h2: ms = `DIRG_HOLD_MS_2;
            3'h3: ms = `DIRG_HOLD_MS_3;
            3'h4: ms = `DIRG_HOLD_MS_4;
            3'h5: ms = `DIRG_HOLD_MS_5;
            3'h6: ms = `DIRG_HOLD_MS_6;
            default: ms = `DIRG_HOLD_MS_7;
        endcase
        return `DIRG_MS_CYCLES(ms);
    endfunction : dirg_hold_lookup

endpackage : dirg_pkg
`default_nettype wire

// *** rtl/dirg_sync.sv ***
// Two-flop synchroniser with edge detection for the two request inputs.
// Assumes inputs idle high; edges are ignored until the chain has settled.
`timescale 1ns/1ps
`default_nettype none
`include "dirg_defines.svh"

module dirg_sync
    import dirg_pkg::*;
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Raw inputs
    input  wire logic [1:0] raw_n,
    // Synchronised level and edges
    output logic      [1:0] level_n,
    output logic      [1:0] fall,
    output logic      [1:0] rise
);

    logic [1:0]                meta_reg;
    logic [1:0]                sync_reg;
    logic [1:0]                hist_reg;
    logic [`DIRG_SETTLE_W-1:0] settle_reg;
    logic                      settled;

    // Edges during settling would fake a press at power-up
    assign settled = (settle_reg == `DIRG_SETTLE_LAST);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            settle_reg <= '0;
        end else if (!settled) begin
            settle_reg <= settle_reg + `DIRG_SETTLE_W'(1);
        end
    end

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_bit
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    meta_reg[i] <= 1'b1;
                    sync_reg[i] <= 1'b1;
                    hist_reg[i] <= 1'b1;
                end else begin
                    meta_reg[i] <= raw_n[i];
                    sync_reg[i] <= meta_reg[i];
                    hist_reg[i] <= sync_reg[i];
                end
            end
            assign level_n[i] = sync_reg[i];
            assign fall[i]    = settled & hist_reg[i] & ~sync_reg[i];
            assign rise[i]    = settled & ~hist_reg[i] & sync_reg[i];
        end
    endgenerate

endmodule : dirg_sync
`default_nettype wire

// *** rtl/dirg_reset_gen.sv ***
// Dual input hold reset generator with accelerated test mode.
// Assumes push-button inputs idle high and an external pull-up on the reset net.
`timescale 1ns/1ps
`default_nettype none
`include "dirg_defines.svh"

module dirg_reset_gen
    import dirg_pkg::*;
#(
    parameter logic [2:0]  hold_option       = 3'h0,
    parameter bit          long_pulse        = 1'b0,
    parameter int unsigned hold_cycles       = dirg_hold_lookup(hold_option),
    parameter int unsigned pulse_cycles      = long_pulse ?
                                               `DIRG_US_CYCLES(`DIRG_PULSE_LONG_US) :
                                               `DIRG_US_CYCLES(`DIRG_PULSE_SHORT_US),
    parameter int unsigned test_delay_cycles = `DIRG_US_CYCLES(`DIRG_TEST_DELAY_US)
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // Request inputs
    input  wire logic first_request_input_n,
    input  wire logic second_request_input_n,
    // Open-drain reset pin
    output logic      reset_out_n,
    output logic      reset_out_oe,
    // Status
    output logic      test_mode_active
);

    localparam int unsigned win_cycles = `DIRG_US_CYCLES(`DIRG_TEST_WINDOW_US);
    localparam logic [`DIRG_TIMER_W-1:0] hold_last  = `DIRG_TIMER_W'(hold_cycles - 1);
    localparam logic [`DIRG_TIMER_W-1:0] pulse_last = `DIRG_TIMER_W'(pulse_cycles - 1);
    localparam logic [`DIRG_TIMER_W-1:0] delay_last = `DIRG_TIMER_W'(test_delay_cycles - 1);
    localparam logic [`DIRG_WIN_W-1:0]   win_last   = `DIRG_WIN_W'(win_cycles - 1);
    localparam logic [`DIRG_EDGE_W-1:0]  edge_last  = `DIRG_EDGE_W'(`DIRG_TEST_PULSES - 1);

    logic [1:0]               level_n;
    logic [1:0]               fall;
    logic [1:0]               rise;

    dirg_state_type           state_reg;
    dirg_state_type           state_next;
    logic [`DIRG_TIMER_W-1:0] timer_reg;
    logic [`DIRG_TIMER_W-1:0] timer_next;
    logic                     armed_reg;
    logic                     armed_next;
    logic                     win_active_reg;
    logic                     win_active_next;
    logic [`DIRG_WIN_W-1:0]   win_cnt_reg;
    logic [`DIRG_WIN_W-1:0]   win_cnt_next;
    logic [`DIRG_EDGE_W-1:0]  edge_cnt_reg;
    logic [`DIRG_EDGE_W-1:0]  edge_cnt_next;
    logic                     in_test_reg;
    logic                     in_test_next;
    logic                     oe_reg;
    logic                     oe_next;
    logic                     out_n_reg;

    dirg_sync u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .raw_n   ({second_request_input_n, first_request_input_n}),
        .level_n (level_n),
        .fall    (fall),
        .rise    (rise)
    );

    // Decoding
    wire both_low    = ~level_n[0] & ~level_n[1];
    wire both_high   = level_n[0] & level_n[1];
    wire first_low   = ~level_n[0];
    wire any_fall    = |fall;
    wire normal_st   = (state_reg == st_idle) || (state_reg == st_hold);
    wire hold_done   = (state_reg == st_hold) && both_low && (timer_reg == hold_last);
    wire pulse_done  = (state_reg == st_pulse) && (timer_reg == pulse_last);
    wire delay_done  = (state_reg == st_test_wait) && (timer_reg == delay_last);
    wire win_expired = win_active_reg && (win_cnt_reg == win_last);
    // Window opens at the first falling edge of the test clock
    wire test_start  = normal_st && first_low && fall[1] && !win_active_reg;
    wire test_hit    = normal_st && win_active_reg && first_low && rise[1] &&
                       !win_expired && (edge_cnt_reg == edge_last);
    wire enter_pulse = (state_next == st_pulse) && (state_reg != st_pulse);

    // Main sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            st_idle: begin
                if (test_hit) begin
                    state_next = st_test_wait;
                end else if (both_low && armed_reg) begin
                    state_next = st_hold;
                end
            end
            st_hold: begin
                if (test_hit) begin
                    state_next = st_test_wait;
                end else if (!both_low) begin
                    state_next = st_idle;
                end else if (hold_done) begin
                    state_next = st_pulse;
                end
            end
            st_pulse: begin
                if (pulse_done) begin
                    state_next = st_idle;
                end
            end
            st_test_wait: begin
                if (both_high) begin
                    state_next = st_idle;
                end else if (delay_done) begin
                    state_next = st_pulse;
                end
            end
            default: state_next = st_idle;
        endcase
    end

    // One timer serves hold, pulse and test delay; restarts on every state change
    assign timer_next = (state_next != state_reg || state_next == st_idle) ?
                        '0 : timer_reg + `DIRG_TIMER_W'(1);

    // A new fall wins over the clear at pulse entry
    assign armed_next = any_fall | (armed_reg & ~enter_pulse);

    assign win_active_next = test_start ? 1'b1 :
                             (!first_low || win_expired || test_hit || !normal_st) ?
                             1'b0 : win_active_reg;
    assign win_cnt_next    = win_active_next && !test_start ?
                             win_cnt_reg + `DIRG_WIN_W'(1) : '0;
    assign edge_cnt_next   = !win_active_next ? '0 :
                             (win_active_reg && rise[1]) ?
                             edge_cnt_reg + `DIRG_EDGE_W'(1) : edge_cnt_reg;

    assign in_test_next = (state_next == st_test_wait) ? 1'b1 :
                          (state_next == st_idle) ? 1'b0 : in_test_reg;

    // Pull only during the pulse; released otherwise for a wired-OR net
    assign oe_next = (state_next == st_pulse);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg <= st_idle;
            timer_reg <= '0;
            armed_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            armed_reg <= armed_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            win_active_reg <= 1'b0;
            win_cnt_reg    <= '0;
            edge_cnt_reg   <= '0;
        end else begin
            win_active_reg <= win_active_next;
            win_cnt_reg    <= win_cnt_next;
            edge_cnt_reg   <= edge_cnt_next;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            in_test_reg <= 1'b0;
            oe_reg      <= 1'b0;
            out_n_reg   <= 1'b0;
        end else begin
            in_test_reg <= in_test_next;
            oe_reg      <= oe_next;
            out_n_reg   <= 1'b0;
        end
    end

    assign reset_out_n      = out_n_reg;
    assign reset_out_oe     = oe_reg;
    assign test_mode_active = in_test_reg;

    // Checking helpers
    logic [`DIRG_TIMER_W-1:0] oe_len_reg;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            oe_len_reg <= '0;
        end else begin
            oe_len_reg <= oe_reg ? oe_len_reg + `DIRG_TIMER_W'(1) : '0;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    hold_expiry_a: assert property (
        hold_done && !test_hit |=> reset_out_oe && state_reg == st_pulse && !armed_reg)
        else $error("hold expiry did not start the reset pulse");

    hold_start_a: assert property (
        state_reg == st_idle && armed_reg && both_low && !test_hit
        |=> state_reg == st_hold && timer_reg == '0)
        else $error("hold timer did not start from zero");

    hold_clear_a: assert property (
        state_reg == st_hold && !both_low && !test_hit
        |=> state_reg == st_idle ##1 timer_reg == '0)
        else $error("released input did not clear the hold timer");

    no_repeat_a: assert property (
        state_reg == st_idle && !armed_reg && !test_hit |=> state_reg != st_hold)
        else $error("hold cycle started without a new input fall");

    arm_on_fall_a: assert property (
        any_fall |=> armed_reg)
        else $error("input fall did not arm a new hold cycle");

    pulse_width_a: assert property (
        $fell(reset_out_oe) |-> oe_len_reg == `DIRG_TIMER_W'(pulse_cycles))
        else $error("reset pulse width wrong");

    open_drain_a: assert property (
        !reset_out_n && (reset_out_oe == (state_reg == st_pulse)))
        else $error("open-drain output drove high or mismatched pulse");

    power_up_a: assert property (
        $past(rst) |-> !armed_reg && !reset_out_oe)
        else $error("design armed or pulsing right after reset");

    test_entry_a: assert property (
        test_hit |=> state_reg == st_test_wait && test_mode_active)
        else $error("eighth test pulse did not enter test mode");

    test_delay_a: assert property (
        state_reg == st_pulse && $past(state_reg) == st_test_wait
        |-> $past(timer_reg) == delay_last)
        else $error("test delay length wrong");

    test_exit_a: assert property (
        in_test_reg && pulse_done |=> !test_mode_active ##1 state_reg != st_test_wait)
        else $error("test mode not left after its pulse");

    test_abort_a: assert property (
        state_reg == st_test_wait && both_high
        |=> state_reg == st_idle && !reset_out_oe && !test_mode_active)
        else $error("test mode not abandoned with both inputs high");

    idle_release_a: assert property (
        both_high && state_reg != st_pulse |=> !reset_out_oe)
        else $error("reset pulled while idle");

    // Pulse may only follow an expired hold or test delay
    pulse_cause_a: assert property (
        $rose(reset_out_oe) |-> $past(hold_done) || $past(delay_done))
        else $error("reset pulse started without an expired timer");

    idle_quiet_a: assert property (
        state_reg == st_idle |-> !reset_out_oe && timer_reg == '0)
        else $error("idle state pulled the net or kept a count");

    hold_no_pulse_a: assert property (
        state_reg == st_hold && !both_low |=> !reset_out_oe)
        else $error("pulse started after an input was released");

    arm_clear_a: assert property (
        enter_pulse && !any_fall |=> !armed_reg)
        else $error("pulse entry left the hold cycle armed");

    delay_fixed_a: assert property (
        state_reg == st_test_wait && !both_high && timer_reg == delay_last
        |=> state_reg == st_pulse && reset_out_oe)
        else $error("test delay did not end in a reset pulse");

    test_hold_a: assert property (
        state_reg == st_test_wait && !both_high
        |=> state_reg inside {st_test_wait, st_pulse})
        else $error("test delay left for the normal hold");

    // Window bounds keep a slow clock from reaching test mode
    win_bound_a: assert property (
        win_active_reg |-> win_cnt_reg <= win_last)
        else $error("test window ran past its length");

    win_close_a: assert property (
        win_expired |=> !win_active_reg && edge_cnt_reg == '0)
        else $error("expired test window kept counting");

    test_first_a: assert property (
        !first_low |=> !win_active_reg && edge_cnt_reg == '0)
        else $error("test count survived a high first input");

    test_count_a: assert property (
        state_reg != st_test_wait && state_next == st_test_wait
        |-> first_low && edge_cnt_reg == edge_last && rise[1] && !win_expired)
        else $error("test mode entered without eight pulses in the window");

    cover_normal_c: cover property (hold_done ##1 reset_out_oe);
    cover_clear_c:  cover property (state_reg == st_hold ##1 state_reg == st_idle);
    cover_test_c:   cover property (test_hit ##[1:300] state_reg == st_test_wait);
    cover_abort_c:  cover property (state_reg == st_test_wait && both_high);
    cover_expire_c: cover property (win_expired);

endmodule : dirg_reset_gen
`default_nettype wire

// *** sim/dirg_proc_model.sv ***
// Processor reset input on a pulled-up wired-OR net, as seen by the generator.
// Assumes one clock domain and the generator's open-drain pin split into data and enable.
`timescale 1ns/1ps
`default_nettype none

module dirg_proc_model (
    // Clock
    input  wire logic       clk_sys,
    // Generator pin
    input  wire logic       reset_out_n,
    input  wire logic       reset_out_oe,
    // Observed net and pulse record
    output logic            reset_net_n,
    output var logic [31:0] pulse_count,
    output var logic [31:0] last_width
);
    logic [31:0] run_reg   = 32'h0;
    logic [31:0] count_reg = 32'h0;
    logic [31:0] width_reg = 32'h0;

    // External pull-up holds the net high unless the pin pulls it
    assign reset_net_n = reset_out_oe ? reset_out_n : 1'b1;
    assign pulse_count = count_reg;
    assign last_width  = width_reg;

    // Width counted in sampled low cycles; a pulse is logged when it ends
    always @(posedge clk_sys) begin
        if (reset_net_n === 1'b0) begin
            run_reg <= run_reg + 32'h1;
        end else if (run_reg != 32'h0) begin
            count_reg <= count_reg + 32'h1;
            width_reg <= run_reg;
            run_reg   <= 32'h0;
        end
    end
endmodule : dirg_proc_model
`default_nettype wire

// *** sim/dual_input_hold_reset_generator_bench.sv ***
// Self-checking bench for the dual input hold reset generator.
// Assumes shortened hold, pulse and test delay counts; window stays at 1400 cycles.
`timescale 1ns/1ps
`default_nettype none

module dual_input_hold_reset_generator_bench;
    localparam int hold_c  = 50;
    localparam int pulse_c = 20;
    localparam int delay_c = 30;
    localparam int win_c   = 1400;

    logic        clk_sys  = 1'b0;
    logic        rst      = 1'b1;
    logic        first_n  = 1'b1;
    logic        second_n = 1'b1;
    logic        reset_out_n;
    logic        reset_out_oe;
    logic        test_mode_active;
    logic        reset_net_n;
    logic [31:0] pulse_count;
    logic [31:0] last_width;
    int          err_count  = 0;
    int          n_tests    = 0;
    int          exp_pulses = 0;

    always #12.5 clk_sys = ~clk_sys;

    dirg_reset_gen #(.hold_option(3'h0), .long_pulse(1'b0), .hold_cycles(hold_c),
                     .pulse_cycles(pulse_c), .test_delay_cycles(delay_c)) dut (
        .clk_sys(clk_sys), .rst(rst), .first_request_input_n(first_n),
        .second_request_input_n(second_n), .reset_out_n(reset_out_n),
        .reset_out_oe(reset_out_oe), .test_mode_active(test_mode_active));

    dirg_proc_model partner (
        .clk_sys(clk_sys), .reset_out_n(reset_out_n), .reset_out_oe(reset_out_oe),
        .reset_net_n(reset_net_n), .pulse_count(pulse_count), .last_width(last_width));

    task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask : check_val

    task automatic check_range(input string what, input int lo, input int hi, input int got);
        n_tests++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
        end
    endtask : check_range

    // Sample 1 ns after the edge so the edge's updates have landed
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic cycles(input int n);
        repeat (n) tick();
    endtask : cycles

    task automatic drive(input logic f, input logic s);
        @(posedge clk_sys);
        first_n  <= f;
        second_n <= s;
        #1;
    endtask : drive

    task automatic wait_net(input logic lvl, input int limit, output int n);
        n = 0;
        while (reset_net_n !== lvl && n < limit) begin
            tick();
            n++;
        end
    endtask : wait_net

    // Finish a pulse and judge its width and the running count
    task automatic pulse_done();
        int n;
        wait_net(1'b1, pulse_c + 10, n);
        cycles(2);
        exp_pulses++;
        check_val("pulse width", pulse_c, last_width);
        check_val("pulse count", exp_pulses, pulse_count);
    endtask : pulse_done

    // 1 MHz test clock: 20 cycles low, 20 high; ends on the last rise
    task automatic test_clk(input int pulses);
        for (int i = 0; i < pulses; i++) begin
            drive(1'b0, 1'b0);
            cycles(19);
            drive(1'b0, 1'b1);
            if (i < pulses - 1) cycles(19);
        end
    endtask : test_clk

    task automatic t_idle();
        cycles(50);
        check_val("idle net", 1, reset_net_n);
        check_val("pulses after power", 0, pulse_count);
        check_val("idle test mode", 0, test_mode_active);
    endtask : t_idle

    // Each build option against its nominal timeout in 25 ns cycles
    task automatic t_options();
        int          ms[8] = '{500, 1000, 1500, 2000, 2500, 3000, 4000, 5000};
        int unsigned got;
        for (int i = 0; i < 8; i++) begin
            got = dirg_pkg::dirg_hold_lookup(3'(i));
            check_val("hold option", ms[i] * 40000, got);
        end
    endtask : t_options

    task automatic t_hold(input bit first_leads);
        int n;
        if (first_leads) drive(1'b0, 1'b1);
        else drive(1'b1, 1'b0);
        cycles(10);
        drive(1'b0, 1'b0);
        wait_net(1'b0, hold_c + 20, n);
        check_range("hold time", hold_c + 2, hold_c + 4, n);
        pulse_done();
        cycles(3 * hold_c);
        check_val("no second pulse", exp_pulses, pulse_count);
        drive(1'b1, 1'b1);
        cycles(5);
    endtask : t_hold

    task automatic t_release();
        int n;
        drive(1'b0, 1'b0);
        cycles(hold_c / 2);
        drive(1'b1, 1'b0);
        cycles(hold_c);
        check_val("early release", exp_pulses, pulse_count);
        drive(1'b0, 1'b0);
        wait_net(1'b0, hold_c + 20, n);
        check_range("restart time", hold_c + 2, hold_c + 4, n);
        pulse_done();
        drive(1'b0, 1'b1);
        cycles(3);
        drive(1'b0, 1'b0);
        wait_net(1'b0, hold_c + 20, n);
        check_range("rearm time", hold_c + 2, hold_c + 4, n);
        pulse_done();
        drive(1'b1, 1'b1);
        cycles(5);
    endtask : t_release

    task automatic t_power();
        @(posedge clk_sys);
        first_n  <= 1'b0;
        second_n <= 1'b0;
        rst      <= 1'b1;
        cycles(20);
        @(posedge clk_sys);
        rst <= 1'b0;
        cycles(3 * hold_c);
        check_val("held through reset", exp_pulses, pulse_count);
        drive(1'b1, 1'b1);
        cycles(5);
    endtask : t_power

    task automatic enter_test(output int n);
        drive(1'b0, 1'b1);
        cycles(40);
        test_clk(8);
        n = 0;
        while (test_mode_active !== 1'b1 && n < 10) begin
            tick();
            n++;
        end
        check_range("test entry", 2, 6, n);
    endtask : enter_test

    task automatic t_test();
        int n;
        enter_test(n);
        wait_net(1'b0, delay_c + 10, n);
        check_range("test delay", delay_c - 1, delay_c + 1, n);
        pulse_done();
        check_val("test mode left", 0, test_mode_active);
        drive(1'b1, 1'b1);
        cycles(5);
    endtask : t_test

    task automatic t_abort();
        int n;
        enter_test(n);
        drive(1'b1, 1'b1);
        cycles(3);
        check_val("abort", 0, test_mode_active);
        cycles(delay_c + pulse_c + 10);
        check_val("abort pulse", exp_pulses, pulse_count);
    endtask : t_abort

    // Slow entry: the window runs out before the eighth pulse
    task automatic t_window();
        drive(1'b0, 1'b1);
        cycles(40);
        test_clk(7);
        cycles(win_c + 100);
        test_clk(1);
        cycles(10);
        check_val("late pulses", 0, test_mode_active);
        drive(1'b1, 1'b1);
        cycles(10);
        check_val("late pulse count", exp_pulses, pulse_count);
    endtask : t_window

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results

    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_idle();
        t_options();
        t_hold(1'b1);
        t_hold(1'b0);
        t_release();
        t_power();
        t_test();
        t_abort();
        t_window();
        results();
    end

    // Whole run is about 3600 cycles; eight times that means a hang
    initial begin
        repeat (30000) @(posedge clk_sys);
        err_count++;
        results();
    end
endmodule : dual_input_hold_reset_generator_bench
`default_nettype wire
